//--- src/bhr_pkg.sv
package bhr_pkg;
  // ==================================================
  // register map (dword address, byte lane)
  localparam logic [5:0] BHR_DW_CACHE = 6'h03; // dword 0ch
  localparam logic [5:0] BHR_DW_BUS = 6'h06;   // dword 18h
  localparam logic [7:0] BHR_OFF_CACHE_LINE = 8'h0c;
  localparam logic [7:0] BHR_OFF_TENURE = 8'h0d;
  localparam logic [7:0] BHR_OFF_HEADER = 8'h0e;
  localparam logic [7:0] BHR_OFF_UP_BUS = 8'h18;
  localparam logic [7:0] BHR_OFF_DN_BUS = 8'h19;
  localparam logic [7:0] BHR_OFF_HI_BUS = 8'h1a;
  localparam int BHR_LANE_CACHE_LINE = 0;
  localparam int BHR_LANE_TENURE = 1;
  localparam int BHR_LANE_HEADER = 2;
  localparam int BHR_LANE_UP_BUS = 0;
  localparam int BHR_LANE_DN_BUS = 1;
  localparam int BHR_LANE_HI_BUS = 2;
  // ==================================================
  // reset and fixed values
  localparam logic [7:0] BHR_RST_CACHE_LINE = 8'h00;
  localparam logic [7:0] BHR_RST_TENURE = 8'h00;
  localparam logic [7:0] BHR_HEADER_KIND = 8'h01;
  localparam logic [7:0] BHR_RST_BUS = 8'h00;
  localparam logic [7:0] BHR_CACHE_MAX = 8'h10;
  localparam logic [5:0] BHR_HDR_LO = 6'h04; // dword 10h
  localparam logic [5:0] BHR_HDR_HI = 6'h0f; // dword 3ch
  // ==================================================
  // type 1 routing verdicts
  typedef enum logic [3:0] {
    BHR_RT_IGNORE  = 4'h1,
    BHR_RT_CONVERT = 4'h2,
    BHR_RT_FORWARD = 4'h4,
    BHR_RT_SPECIAL = 4'h8
  } bhr_route_e;
endpackage : bhr_pkg

//--- src/bhr_tenure.sv
`timescale 1ns/1ps
// ==================================================
// primary master tenure counter
module bhr_tenure
  import bhr_pkg::*;
(
  input wire logic sys_clk_i,            // pci clock
  input wire logic rstn_i,               // async reset, active low
  input wire logic [7:0] limit_i,        // programmed timer value
  input wire logic frame_start_i,        // frame asserted this cycle as master
  input wire logic mastering_i,          // device owns the primary bus
  input wire logic gnt_i,                // primary grant
  input wire logic data_done_i,          // a data phase completed
  input wire logic mwi_i,                // current cycle is write-and-invalidate
  output logic expired_o,                // timer reached the programmed value
  output logic release_o                 // must give up bus now
);
  logic [7:0] cnt_q;
  logic expired_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 8'h00;
      expired_q <= 1'b0;
    end else if (frame_start_i) begin
      cnt_q <= 8'h00;
      expired_q <= (limit_i == 8'h00);
    end else if (mastering_i && !expired_q) begin
      cnt_q <= cnt_q + 8'h01;
      expired_q <= (cnt_q + 8'h01 >= limit_i);
    end else if (!mastering_i) begin
      expired_q <= 1'b0;
    end
  end
  assign expired_o = expired_q;
  // zero setting: leave after first data once grant drops, mwi exempt
  assign release_o = mastering_i && expired_q && !gnt_i && data_done_i && !mwi_i;

  a_zero_release: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    frame_start_i && limit_i == 8'h00 |=> expired_o)
    else $error("zero timer did not expire at once");
  a_mwi_holds: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mwi_i |-> !release_o)
    else $error("released during write-and-invalidate");
  a_count_limit: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    frame_start_i && limit_i == 8'h03 ##1 mastering_i [*3] |=> expired_o)
    else $error("timer did not expire after programmed cycles");
  c_release: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) release_o);
endmodule : bhr_tenure

//--- src/bhr_regs.sv
`timescale 1ns/1ps
// ==================================================
// What this block does
// - an 8-bit read/write cache line size in dwords sits at 0ch and resets to zero.
// - the cache line size sets prefetch length and write-and-invalidate stop points.
// - a size that is not a power of two or above sixteen acts as zero.
// - as primary master, clocks are counted from frame up to the 8-bit timer value.
// - all eight timer bits are writable, giving single clock resolution.
// - with timer zero the bus is released after first data once grant drops, except mwi.
// - the header type byte is read-only and returns 01h.
// - the header type governs the meaning of config offsets 10h to 3fh.
// - an 8-bit read/write primary bus number resets to zero.
// - secondary type 1 cycles with special cycle encoding to the primary bus number become special cycles.
// - an 8-bit read/write secondary bus number, reset zero, drives primary type 1 claim.
// - a primary type 1 cycle to the secondary number becomes type 0 or special.
// - an 8-bit read/write subordinate bus number resets to zero.
// - secondary and subordinate numbers decide when type 1 passes down as type 1.
module bhr_regs
  import bhr_pkg::*;
(
  input wire logic sys_clk_i,            // primary pci clock
  input wire logic rstn_i,               // pci reset, active low
  input wire logic cfg_sel_i,            // type 0 config access to this device
  input wire logic cfg_wr_i,             // 1 write, 0 read
  input wire logic [5:0] cfg_dw_i,       // dword address
  input wire logic [3:0] cfg_be_n_i,     // byte enables, active low
  input wire logic [31:0] cfg_wdata_i,   // write data
  output logic [31:0] cfg_rdata_o,       // read data, registered
  output logic cfg_hdr_space_o,          // access falls in header-governed range
  input wire logic [7:0] p_t1_bus_i,     // bus of a primary type 1 cycle
  input wire logic p_t1_special_i,       // primary type 1 is special cycle encoding
  output bhr_route_e p_t1_route_o,       // verdict for primary type 1 cycle
  input wire logic [7:0] s_t1_bus_i,     // bus of a secondary type 1 cycle
  input wire logic s_t1_special_i,       // secondary type 1 is special cycle encoding
  output bhr_route_e s_t1_route_o,       // verdict for secondary type 1 cycle
  output logic [7:0] cache_line_o,       // effective cache line size
  output logic [4:0] mwi_mask_o,         // low address bits marking line end
  input wire logic [4:0] mwi_dw_i,       // dword index within line of mwi data
  output logic mwi_line_end_o,           // mwi must stop at this dword
  output logic [7:0] prefetch_len_o,     // dwords to prefetch for memory read
  input wire logic frame_start_i,        // frame asserted as primary master
  input wire logic mastering_i,          // device owns primary bus
  input wire logic gnt_i,                // primary grant
  input wire logic data_done_i,          // data phase completed
  input wire logic mwi_i,                // current command is mwi
  output logic tenure_expired_o,         // latency timer expired
  output logic tenure_release_o          // must release primary bus
);
  logic [7:0] cache_line_length_q;
  logic [7:0] primary_master_tenure_timer_q;
  logic [7:0] upstream_bus_id_q;
  logic [7:0] downstream_bus_id_q;
  logic [7:0] highest_downstream_bus_id_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] cl_eff;
  logic cl_pow2;
  logic wr_cache;
  logic wr_bus;

  assign wr_cache = cfg_sel_i && cfg_wr_i && (cfg_dw_i == BHR_DW_CACHE);
  assign wr_bus = cfg_sel_i && cfg_wr_i && (cfg_dw_i == BHR_DW_BUS);
  assign cfg_hdr_space_o = cfg_sel_i && (cfg_dw_i >= BHR_HDR_LO)
    && (cfg_dw_i <= BHR_HDR_HI);

  // ==================================================
  // writable bytes, each on its own lane
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cache_line_length_q <= BHR_RST_CACHE_LINE;
      primary_master_tenure_timer_q <= BHR_RST_TENURE;
    end else if (wr_cache) begin
      // any value is stored; illegal values are only neutralised on use
      if (!cfg_be_n_i[BHR_LANE_CACHE_LINE])
        cache_line_length_q <= cfg_wdata_i[8*BHR_LANE_CACHE_LINE +: 8];
      if (!cfg_be_n_i[BHR_LANE_TENURE])
        primary_master_tenure_timer_q <= cfg_wdata_i[8*BHR_LANE_TENURE +: 8];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upstream_bus_id_q <= BHR_RST_BUS;
      downstream_bus_id_q <= BHR_RST_BUS;
      highest_downstream_bus_id_q <= BHR_RST_BUS;
    end else if (wr_bus) begin
      if (!cfg_be_n_i[BHR_LANE_UP_BUS])
        upstream_bus_id_q <= cfg_wdata_i[8*BHR_LANE_UP_BUS +: 8];
      if (!cfg_be_n_i[BHR_LANE_DN_BUS])
        downstream_bus_id_q <= cfg_wdata_i[8*BHR_LANE_DN_BUS +: 8];
      if (!cfg_be_n_i[BHR_LANE_HI_BUS])
        highest_downstream_bus_id_q <= cfg_wdata_i[8*BHR_LANE_HI_BUS +: 8];
    end
  end

  // ==================================================
  // read path; other dwords read zero, header byte is fixed
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (cfg_dw_i == BHR_DW_CACHE) begin
      rdata_d[8*BHR_LANE_CACHE_LINE +: 8] = cache_line_length_q;
      rdata_d[8*BHR_LANE_TENURE +: 8] = primary_master_tenure_timer_q;
      rdata_d[8*BHR_LANE_HEADER +: 8] = BHR_HEADER_KIND;
    end else if (cfg_dw_i == BHR_DW_BUS) begin
      rdata_d[8*BHR_LANE_UP_BUS +: 8] = upstream_bus_id_q;
      rdata_d[8*BHR_LANE_DN_BUS +: 8] = downstream_bus_id_q;
      rdata_d[8*BHR_LANE_HI_BUS +: 8] = highest_downstream_bus_id_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (cfg_sel_i && !cfg_wr_i) begin
      rdata_q <= rdata_d;
    end
  end
  assign cfg_rdata_o = rdata_q;

  // ==================================================
  // cache line qualification
  // software may write any size; values that are not powers of two or are above sixteen fall back to zero
  assign cl_pow2 = (cache_line_length_q != 8'h00)
    && ((cache_line_length_q & (cache_line_length_q - 8'h01)) == 8'h00);
  assign cl_eff = (cl_pow2 && cache_line_length_q <= BHR_CACHE_MAX)
    ? cache_line_length_q : 8'h00;
  assign cache_line_o = cl_eff;
  assign mwi_mask_o = (cl_eff == 8'h00) ? 5'h00 : 5'(cl_eff - 8'h01);
  // with no valid line size an mwi ends at each dword boundary
  assign mwi_line_end_o = ((mwi_dw_i & mwi_mask_o) == mwi_mask_o);
  // no valid line: prefetch only a single dword
  assign prefetch_len_o = (cl_eff == 8'h00) ? 8'h01 : cl_eff;

  // ==================================================
  // type 1 routing; meaningful only after software sets bus numbers
  always_comb begin
    if (p_t1_bus_i == downstream_bus_id_q) begin
      p_t1_route_o = p_t1_special_i ? BHR_RT_SPECIAL : BHR_RT_CONVERT;
    end else if (p_t1_bus_i > downstream_bus_id_q
                 && p_t1_bus_i <= highest_downstream_bus_id_q) begin
      p_t1_route_o = BHR_RT_FORWARD;
    end else begin
      p_t1_route_o = BHR_RT_IGNORE;
    end
  end

  always_comb begin
    if (s_t1_special_i && s_t1_bus_i == upstream_bus_id_q) begin
      s_t1_route_o = BHR_RT_SPECIAL;
    end else if (s_t1_bus_i < downstream_bus_id_q
                 || s_t1_bus_i > highest_downstream_bus_id_q) begin
      s_t1_route_o = BHR_RT_FORWARD;
    end else begin
      s_t1_route_o = BHR_RT_IGNORE;
    end
  end

  // ==================================================
  // master tenure
  bhr_tenure u_tenure (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .limit_i(primary_master_tenure_timer_q),
    .frame_start_i(frame_start_i),
    .mastering_i(mastering_i),
    .gnt_i(gnt_i),
    .data_done_i(data_done_i),
    .mwi_i(mwi_i),
    .expired_o(tenure_expired_o),
    .release_o(tenure_release_o)
  );

  // ==================================================
  // checks
  a_header_fixed: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cfg_sel_i && !cfg_wr_i && cfg_dw_i == BHR_DW_CACHE
    |=> cfg_rdata_o[23:16] == 8'h01)
    else $error("header type not 01h");
  a_cache_illegal: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cache_line_length_q > 8'h10 |-> cache_line_o == 8'h00)
    else $error("oversize cache line not zeroed");
  a_cache_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_cache && !cfg_be_n_i[0] |=> cache_line_length_q == $past(cfg_wdata_i[7:0]))
    else $error("cache line write lost");
  a_bus_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_bus && !cfg_be_n_i[1] |=> downstream_bus_id_q == $past(cfg_wdata_i[15:8]))
    else $error("secondary bus write lost");
  a_sub_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_bus && !cfg_be_n_i[2] |=> highest_downstream_bus_id_q == $past(cfg_wdata_i[23:16]))
    else $error("subordinate bus write lost");
  a_up_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_bus && !cfg_be_n_i[0] |=> upstream_bus_id_q == $past(cfg_wdata_i[7:0]))
    else $error("primary bus write lost");
  a_fwd_range: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    p_t1_route_o == BHR_RT_FORWARD |-> p_t1_bus_i > downstream_bus_id_q
    && p_t1_bus_i <= highest_downstream_bus_id_q)
    else $error("forward outside bus range");
  a_convert_eq: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    p_t1_bus_i == downstream_bus_id_q && !p_t1_special_i |-> p_t1_route_o == BHR_RT_CONVERT)
    else $error("secondary bus target not converted");
  a_up_special: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    s_t1_special_i && s_t1_bus_i == upstream_bus_id_q |-> s_t1_route_o == BHR_RT_SPECIAL)
    else $error("upstream special not converted");
  a_pow2_mask: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cache_line_length_q == 8'h08 |-> mwi_mask_o == 5'h07 && prefetch_len_o == 8'h08)
    else $error("line size use wrong");
  c_forward: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    p_t1_route_o == BHR_RT_FORWARD);
  c_convert: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    p_t1_route_o == BHR_RT_CONVERT);
  c_line_valid: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cache_line_o == 8'h10);
  c_special: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    p_t1_route_o == BHR_RT_SPECIAL);

  // ==================================================
  // register storage and read path
  a_timer_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_cache && !cfg_be_n_i[1] |=> primary_master_tenure_timer_q == $past(cfg_wdata_i[15:8]))
    else $error("timer write lost");
  a_cache_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !wr_cache |=> cache_line_length_q == $past(cache_line_length_q))
    else $error("cache line changed without write");
  a_bus_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !wr_bus |=> upstream_bus_id_q == $past(upstream_bus_id_q)
    && downstream_bus_id_q == $past(downstream_bus_id_q)
    && highest_downstream_bus_id_q == $past(highest_downstream_bus_id_q))
    else $error("bus number changed without write");
  a_rd_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !(cfg_sel_i && !cfg_wr_i) |=> cfg_rdata_o == $past(cfg_rdata_o))
    else $error("read data moved without read");
  a_rd_unmapped: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cfg_sel_i && !cfg_wr_i && cfg_dw_i != 6'h03 && cfg_dw_i != 6'h06
    |=> cfg_rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rd_dw3: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cfg_sel_i && !cfg_wr_i && cfg_dw_i == 6'h03 |=> cfg_rdata_o[31:24] == 8'h00
    && cfg_rdata_o[15:0] == {$past(primary_master_tenure_timer_q), $past(cache_line_length_q)})
    else $error("cache dword read wrong");
  a_rd_bus: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cfg_sel_i && !cfg_wr_i && cfg_dw_i == 6'h06 |=> cfg_rdata_o == {8'h00,
    $past(highest_downstream_bus_id_q), $past(downstream_bus_id_q), $past(upstream_bus_id_q)})
    else $error("bus dword read wrong");
  a_hdr_range: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cfg_hdr_space_o |-> cfg_sel_i && cfg_dw_i >= 6'h04 && cfg_dw_i <= 6'h0f)
    else $error("header range flag outside 10h to 3fh");
  a_hdr_below: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cfg_sel_i && cfg_dw_i == 6'h03 |-> !cfg_hdr_space_o)
    else $error("header range flag on dword 0ch");

  // ==================================================
  // cache line use
  a_cache_npow2: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (cache_line_length_q & (cache_line_length_q - 8'h01)) != 8'h00 |-> cache_line_o == 8'h00)
    else $error("non power of two size used");
  a_cache_pass: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cache_line_o != 8'h00 |-> cache_line_o == cache_line_length_q)
    else $error("valid size altered");
  a_cache_zero_use: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cache_line_o == 8'h00 |-> prefetch_len_o == 8'h01 && mwi_mask_o == 5'h00 && mwi_line_end_o)
    else $error("zero size use wrong");
  a_mask_size: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cache_line_o != 8'h00 |-> {3'b000, mwi_mask_o} == cache_line_o - 8'h01)
    else $error("mwi mask does not match size");
  a_prefetch_len: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    cache_line_o != 8'h00 |-> prefetch_len_o == cache_line_o)
    else $error("prefetch length does not match size");
  a_line_end: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mwi_line_end_o |-> (mwi_dw_i & mwi_mask_o) == mwi_mask_o)
    else $error("mwi stopped inside a line");

  // ==================================================
  // routing and tenure
  a_special_dn: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    p_t1_bus_i == downstream_bus_id_q && p_t1_special_i |-> p_t1_route_o == BHR_RT_SPECIAL)
    else $error("secondary bus special not converted");
  a_ignore_out: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    p_t1_bus_i != downstream_bus_id_q && (p_t1_bus_i < downstream_bus_id_q
    || p_t1_bus_i > highest_downstream_bus_id_q) |-> p_t1_route_o == BHR_RT_IGNORE)
    else $error("claimed type 1 outside range");
  a_s_forward: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !(s_t1_special_i && s_t1_bus_i == upstream_bus_id_q) && (s_t1_bus_i < downstream_bus_id_q
    || s_t1_bus_i > highest_downstream_bus_id_q) |-> s_t1_route_o == BHR_RT_FORWARD)
    else $error("upstream type 1 not forwarded");
  a_s_inside: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !(s_t1_special_i && s_t1_bus_i == upstream_bus_id_q) && s_t1_bus_i >= downstream_bus_id_q
    && s_t1_bus_i <= highest_downstream_bus_id_q |-> s_t1_route_o == BHR_RT_IGNORE)
    else $error("downstream type 1 sent upstream");
  a_release_cond: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    tenure_release_o |-> mastering_i && !gnt_i && data_done_i && !mwi_i)
    else $error("release without its conditions");
  a_expire_idle: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !mastering_i && !frame_start_i |=> !tenure_expired_o)
    else $error("timer expired while not mastering");
endmodule : bhr_regs

//--- tb/bhr_cfg_master.sv
`timescale 1ns/1ps
// ==================================================
// primary bus configuration master model
module bhr_cfg_master (
  input wire logic sys_clk_i,           // pci clock
  input wire logic [31:0] cfg_rdata_i,  // read data from the bridge
  output logic cfg_sel_o,               // access strobe
  output logic cfg_wr_o,                // 1 write, 0 read
  output logic [5:0] cfg_dw_o,          // dword address
  output logic [3:0] cfg_be_n_o,        // byte enables, active low
  output logic [31:0] cfg_wdata_o       // write data
);
  initial begin
    cfg_sel_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_dw_o = 6'h00;
    cfg_be_n_o = 4'hf;
    cfg_wdata_o = 32'h0000_0000;
  end
  // ==================================================
  // one access, entered at a falling edge; back to back calls keep the strobe up
  // software writes any cache line size, legal or not, and writes bus numbers before routing is used
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be_n,
                        input logic [31:0] wd, output logic [31:0] rd);
    cfg_sel_o <= 1'b1;
    cfg_wr_o <= wr;
    cfg_dw_o <= dw;
    cfg_be_n_o <= be_n;
    cfg_wdata_o <= wr ? wd : ~cfg_wdata_o;
    @(negedge sys_clk_i);
    rd = cfg_rdata_i;
  endtask : access
  // a released data bus keeps toggling so stale values never look valid
  task automatic idle();
    cfg_sel_o <= 1'b0;
    cfg_wdata_o <= ~cfg_wdata_o;
    @(negedge sys_clk_i);
  endtask : idle
endmodule : bhr_cfg_master

//--- tb/test_bhr_regs.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_bhr_regs
  import bhr_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sel, wr, hdr, fs = 1'b0, ms = 1'b0, gnt = 1'b1, dd = 1'b0, mwi = 1'b0;
  logic ps = 1'b0, ss = 1'b0, eol, exp_o, rel;
  logic [5:0] dw;
  logic [3:0] be_n;
  logic [31:0] wd, rdata, rd;
  logic [7:0] pb = 8'h00, sb = 8'h00, cl, pf;
  logic [4:0] mask, mdw = 5'h02;
  bhr_route_e pr, sr;
  int num_errors = 0;
  int check_count = 0;
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  bhr_cfg_master m (.sys_clk_i(sys_clk_i), .cfg_rdata_i(rdata), .cfg_sel_o(sel), .cfg_wr_o(wr),
    .cfg_dw_o(dw), .cfg_be_n_o(be_n), .cfg_wdata_o(wd));
  bhr_regs dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cfg_sel_i(sel), .cfg_wr_i(wr),
    .cfg_dw_i(dw), .cfg_be_n_i(be_n), .cfg_wdata_i(wd), .cfg_rdata_o(rdata),
    .cfg_hdr_space_o(hdr), .p_t1_bus_i(pb), .p_t1_special_i(ps), .p_t1_route_o(pr),
    .s_t1_bus_i(sb), .s_t1_special_i(ss), .s_t1_route_o(sr), .cache_line_o(cl),
    .mwi_mask_o(mask), .mwi_dw_i(mdw), .mwi_line_end_o(eol), .prefetch_len_o(pf),
    .frame_start_i(fs), .mastering_i(ms), .gnt_i(gnt), .data_done_i(dd), .mwi_i(mwi),
    .tenure_expired_o(exp_o), .tenure_release_o(rel));
  // ==================================================
  // scenarios
  task automatic t_regs();
    m.access(1'b0, 6'h03, 4'h0, 32'h0, rd);
    `CHK("reset dw3", 32'h0001_0000, rd)
    m.access(1'b0, 6'h06, 4'h0, 32'h0, rd);
    `CHK("reset dw6", 32'h0000_0000, rd)
    m.access(1'b1, 6'h03, 4'b0100, 32'hffff_ff5a, rd);
    m.access(1'b1, 6'h03, 4'b1110, 32'h0000_0004, rd);
    m.access(1'b0, 6'h03, 4'h0, 32'h0, rd);
    `CHK("dw3 lanes", 32'h0001_ff04, rd)
    `CHK("hdr space dw3", 1'b0, hdr)
    m.access(1'b1, 6'h06, 4'h0, 32'haa09_0502, rd);
    m.access(1'b0, 6'h06, 4'h0, 32'h0, rd);
    `CHK("bus numbers", 32'h0009_0502, rd)
    m.access(1'b0, 6'h04, 4'h0, 32'h0, rd);
    `CHK("hdr space dw4", 1'b1, hdr)
    m.idle();
  endtask : t_regs
  task automatic t_cache();
    logic [7:0] v[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h10, 8'h11, 8'h20, 8'h0c};
    logic [7:0] e[10] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h04, 8'h08, 8'h10, 8'h00, 8'h00, 8'h00};
    logic [4:0] k;
    for (int i = 0; i < 10; i++) begin
      m.access(1'b1, 6'h03, 4'b1110, {24'h0, v[i]}, rd);
      k = (e[i] == 8'h00) ? 5'h00 : 5'(e[i] - 8'h01);
      `CHK("cache line", e[i], cl)
      `CHK("prefetch", (e[i] == 8'h00) ? 8'h01 : e[i], pf)
      `CHK("mwi mask", k, mask)
      `CHK("mwi end", ((5'h02 & k) == k), eol)
    end
    m.idle();
  endtask : t_cache
  task automatic t_route();
    logic [7:0] b[6] = '{8'h05, 8'h05, 8'h06, 8'h09, 8'h0a, 8'h04};
    logic [8:0] x[6] = '{9'h002, 9'h108, 9'h004, 9'h004, 9'h001, 9'h001};
    logic [8:0] y[6] = '{9'h001, 9'h101, 9'h001, 9'h001, 9'h004, 9'h004};
    for (int i = 0; i < 6; i++) begin
      pb = b[i];
      ps = x[i][8];
      sb = b[i];
      ss = y[i][8];
      #1;
      `CHK("primary route", x[i][3:0], pr)
      `CHK("secondary route", y[i][3:0], sr)
    end
    sb = 8'h02;
    ss = 1'b1;
    #1;
    `CHK("special up", 4'h8, sr)
    @(negedge sys_clk_i);
  endtask : t_route
  task automatic t_tenure();
    m.access(1'b1, 6'h03, 4'b1101, 32'h0, rd);
    m.idle();
    fs = 1'b1;
    ms = 1'b1;
    @(negedge sys_clk_i);
    fs = 1'b0;
    `CHK("expired at zero", 1'b1, exp_o)
    gnt = 1'b0;
    dd = 1'b1;
    mwi = 1'b1;
    #1;
    `CHK("hold for mwi", 1'b0, rel)
    mwi = 1'b0;
    #1;
    `CHK("release", 1'b1, rel)
    ms = 1'b0;
    dd = 1'b0;
    gnt = 1'b1;
    @(negedge sys_clk_i);
    `CHK("cleared", 1'b0, exp_o)
    m.access(1'b1, 6'h03, 4'b1101, 32'h0000_0300, rd);
    m.idle();
    fs = 1'b1;
    ms = 1'b1;
    @(negedge sys_clk_i);
    fs = 1'b0;
    @(negedge sys_clk_i);
    `CHK("not yet expired", 1'b0, exp_o)
    repeat (3) @(negedge sys_clk_i);
    `CHK("expired", 1'b1, exp_o)
    ms = 1'b0;
    @(negedge sys_clk_i);
  endtask : t_tenure
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rstn_i = 1'b1;
    t_regs();
    t_cache();
    t_route();
    t_tenure();
    give_verdict();
  end
  initial begin
    #(500 * 50);
    num_errors++;
    give_verdict();
  end
endmodule : test_bhr_regs
